// *** core/dev_cmd_pkg.sv ***
package dev_cmd_pkg;
   // one-hot command-layer states
   typedef enum logic [11:0] {
      ST_IDLE            = 12'h001,
      ST_SET_SERVICE     = 12'h002,
      ST_SERVICE_CHECK   = 12'h004,
      ST_TAG_SEND        = 12'h008,
      ST_SERVICE_DISPATCH = 12'h010,
      ST_RESET_ASSERTED  = 12'h020,
      ST_RUN_DIAGNOSTICS = 12'h040,
      ST_SOFT_RESET_BIT_GOOD       = 12'h080,
      ST_SOFT_RESET_BIT_BAD        = 12'h100,
      ST_EDD_DIAG        = 12'h200,
      ST_EDD_GOOD        = 12'h400,
      ST_EDD_BAD         = 12'h800
   } fsm_state_t;
   // frame kinds handed to the transport layer
   typedef enum logic [1:0] {
      FRAME_NONE    = 2'h0,
      FRAME_SDB     = 2'h1,
      FRAME_REG_D2H = 2'h2
   } frame_kind_t;
   // serviced command type, also the dispatch target
   typedef enum logic [2:0] {
      CMD_PKT_PIO_IN  = 3'h0,
      CMD_PKT_PIO_OUT = 3'h1,
      CMD_PKT_DMA_IN  = 3'h2,
      CMD_PKT_DMA_OUT = 3'h3,
      CMD_RD_DMA_Q    = 3'h4,
      CMD_WR_DMA_Q    = 3'h5
   } cmd_type_t;
   localparam int TAG_W = 5;
   localparam int SERVICE_BIT_POS = 4;
   localparam int DATA_REQ_BIT_POS = 3;
   localparam int TAG_LSB = 3;
   localparam int STATUS_DEV_LSB = 4;
   localparam logic [7:0] SIG_COUNT = 8'h01;
   localparam logic [7:0] SIG_LBA_LOW = 8'h01;
   localparam logic [7:0] SIG_LBA_MID_ATA = 8'h00;
   localparam logic [7:0] SIG_LBA_HIGH_ATA = 8'h00;
   localparam logic [7:0] SIG_LBA_MID_PKT = 8'h14;
   localparam logic [7:0] SIG_LBA_HIGH_PKT = 8'hEB;
   localparam logic [7:0] SIG_ERR_GOOD = 8'h01;
   localparam logic [7:0] SIG_ERR_BAD_DEFAULT = 8'h00;
   localparam logic [7:0] SIG_ERR_BAD_MAX = 8'h7F;
   localparam logic [7:0] SIG_STATUS_PKT = 8'h00;
endpackage : dev_cmd_pkg

// *** core/frame_req_if.sv ***
`timescale 1ns/100ps
interface frame_req_if;
   import dev_cmd_pkg::*;
   logic want;
   frame_kind_t kind;
   logic irq;
   logic [7:0] count;
   logic [23:0] lba;
   logic [7:0] err;
   logic [7:0] status;
   logic busy;
   logic done;
   modport fsm (output want, kind, irq, count, lba, err, status, input busy, done);
   modport holder (input want, kind, irq, count, lba, err, status, output busy, done);
endinterface : frame_req_if

// *** core/reset_signature_gen.sv ***
`timescale 1ns/100ps
module reset_signature_gen
   import dev_cmd_pkg::*;
(
   input wire logic packet_support_i,
   input wire logic good_i,
   input wire logic [2:0] status_bits_i,
   input wire logic [7:0] fail_code_i,
   output logic [7:0] count_o,
   output logic [23:0] lba_o,
   output logic [7:0] err_o,
   output logic [7:0] status_o
);
   // 01h and codes above 7Fh would read as a pass, so they fold to 00h
   function automatic logic [7:0] legal_fail(input logic [7:0] code);
      if (code == SIG_ERR_GOOD || code > SIG_ERR_BAD_MAX)
      begin
         return SIG_ERR_BAD_DEFAULT;
      end
      return code;
   endfunction : legal_fail

   // signature fields, packet devices carry the 14h/EBh marker
   assign count_o = SIG_COUNT;
   assign lba_o = packet_support_i ? {SIG_LBA_HIGH_PKT, SIG_LBA_MID_PKT, SIG_LBA_LOW}
                                   : {SIG_LBA_HIGH_ATA, SIG_LBA_MID_ATA, SIG_LBA_LOW};
   assign err_o = good_i ? SIG_ERR_GOOD : legal_fail(fail_code_i);
   assign status_o = packet_support_i ? SIG_STATUS_PKT
                                      : {1'b0, status_bits_i, 4'h0};
endmodule : reset_signature_gen

// *** core/tx_request_hold.sv ***
`timescale 1ns/100ps
module tx_request_hold
   import dev_cmd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic abort_i,
   frame_req_if.holder req,
   input wire logic tx_done_i,
   output logic tx_req_o,
   output frame_kind_t tx_kind_o,
   output logic tx_irq_o,
   output logic [7:0] tx_count_o,
   output logic [23:0] tx_lba_o,
   output logic [7:0] tx_err_o,
   output logic [7:0] tx_status_o
);
   logic busy_q;
   wire launch = req.want && !busy_q;

   assign req.busy = busy_q;
   assign req.done = busy_q && tx_done_i;
   assign tx_req_o = busy_q;

   // one request at a time, held until the transport answers or abort_i drops it
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i || abort_i)
      begin
         busy_q <= 1'b0;
      end
      else if (launch)
      begin
         busy_q <= 1'b1;
      end
      else if (req.done)
      begin
         busy_q <= 1'b0;
      end
   end

   // frame fields frozen for the whole request
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         tx_kind_o <= FRAME_NONE;
         tx_irq_o <= 1'b0;
         tx_count_o <= 8'h00;
         tx_lba_o <= 24'h000000;
         tx_err_o <= 8'h00;
         tx_status_o <= 8'h00;
      end
      else if (launch)
      begin
         tx_kind_o <= req.kind;
         tx_irq_o <= req.irq;
         tx_count_o <= req.count;
         tx_lba_o <= req.lba;
         tx_err_o <= req.err;
         tx_status_o <= req.status;
      end
   end

   property p_req_held;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      tx_req_o && !tx_done_i && !abort_i |=> tx_req_o && $stable(tx_status_o);
   endproperty
   a_req_held: assert property (p_req_held)
      else $error("frame request dropped before completion");
endmodule : tx_request_hold

// *** core/device_reset_service_fsm.sv ***
`timescale 1ns/100ps
// What this block does
// - service request sends flagged set-device-bits frame
// - service frame sent returns to idle
// - packet PIO skips tag frame, others send it
// - tag step sends register frame with tag
// - dispatch branches to data phase by type
// - soft reset frame enters reset in any mode
// - host sets then clears soft reset, device initializes
// - release frame moves to diagnostics run
// - command or soft reset frame keeps reset state
// - diagnostics result picks good or bad status
// - non-packet good signature, status bits 6:4 chosen
// - packet good signature with 14h EBh
// - non-packet bad signature, legal error code
// - packet bad signature with 14h EBh
// - status frame sent returns to idle
// - link reset abandons diagnostic command at once
// - soft reset restarts reset protocol at once
// - diagnostic command result picks good or bad
// - diagnostic command status frame raises interrupt
module device_reset_service_fsm
   import dev_cmd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic rx_frame_valid_i,
   input wire logic rx_reg_h2d_i,
   input wire logic rx_cmd_flag_i,
   input wire logic rx_soft_reset_i,
   input wire logic comreset_i,
   input wire logic queue_ready_i,
   input wire logic service_cmd_i,
   input wire cmd_type_t service_request_bit_cmd_type_i,
   input wire logic [TAG_W-1:0] service_request_bit_tag_i,
   input wire logic diag_cmd_i,
   input wire logic diag_done_i,
   input wire logic diag_pass_i,
   input wire logic packet_support_i,
   input wire logic [2:0] status_bits_i,
   input wire logic [7:0] fail_code_i,
   input wire logic [7:0] err_reg_i,
   input wire logic [7:0] status_reg_i,
   input wire logic tx_done_i,
   output logic tx_req_o,
   output frame_kind_t tx_kind_o,
   output logic tx_irq_o,
   output logic [7:0] tx_count_o,
   output logic [23:0] tx_lba_o,
   output logic [7:0] tx_err_o,
   output logic [7:0] tx_status_o,
   output logic dispatch_valid_o,
   output cmd_type_t dispatch_cmd_o,
   output logic diag_restart_o,
   output logic idle_o
);
   fsm_state_t state_q;
   fsm_state_t state_d;
   logic [TAG_W-1:0] tag_q;
   logic diag_done_q;
   logic diag_pass_q;
   logic diag_restart_d;
   logic [7:0] sig_count;
   logic [23:0] sig_lba;
   logic [7:0] sig_err;
   logic [7:0] sig_status;

   frame_req_if req ();

   // states that own a transmit request
   function automatic logic is_send(input fsm_state_t s);
      return (s == ST_SET_SERVICE) || (s == ST_TAG_SEND) ||
             (s == ST_SOFT_RESET_BIT_GOOD) || (s == ST_SOFT_RESET_BIT_BAD) ||
             (s == ST_EDD_GOOD) || (s == ST_EDD_BAD);
   endfunction : is_send

   // received register frame decode
   wire reg_frame = rx_frame_valid_i && rx_reg_h2d_i;
   wire soft_reset_bit_frame = reg_frame && !rx_cmd_flag_i && rx_soft_reset_i;
   wire release_frame = reg_frame && !rx_cmd_flag_i && !rx_soft_reset_i;
   wire pio_packet = (dispatch_cmd_o == CMD_PKT_PIO_IN) ||
                     (dispatch_cmd_o == CMD_PKT_PIO_OUT);
   wire diag_ready = diag_done_q || diag_done_i;
   wire diag_ok = diag_done_i ? diag_pass_i : diag_pass_q;
   wire frame_done = req.done;
   wire good_state = (state_q == ST_SOFT_RESET_BIT_GOOD) || (state_q == ST_EDD_GOOD);
   wire sig_state = good_state || (state_q == ST_SOFT_RESET_BIT_BAD) ||
                    (state_q == ST_EDD_BAD);

   // next state: link reset first, then soft reset, then the state itself
   always_comb
   begin
      state_d = state_q;
      if (comreset_i)
      begin
         state_d = ST_RUN_DIAGNOSTICS;
      end
      else if (soft_reset_bit_frame)
      begin
         state_d = ST_RESET_ASSERTED;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (diag_cmd_i)
               begin
                  state_d = ST_EDD_DIAG;
               end
               else if (service_cmd_i)
               begin
                  state_d = ST_SERVICE_CHECK;
               end
               else if (queue_ready_i)
               begin
                  state_d = ST_SET_SERVICE;
               end
            end
            ST_SET_SERVICE:
            begin
               if (frame_done)
               begin
                  state_d = ST_IDLE;
               end
            end
            ST_SERVICE_CHECK:
            begin
               state_d = pio_packet ? ST_SERVICE_DISPATCH : ST_TAG_SEND;
            end
            ST_TAG_SEND:
            begin
               if (frame_done)
               begin
                  state_d = ST_SERVICE_DISPATCH;
               end
            end
            ST_SERVICE_DISPATCH:
            begin
               state_d = ST_IDLE;
            end
            ST_RESET_ASSERTED:
            begin
               if (release_frame)
               begin
                  state_d = ST_RUN_DIAGNOSTICS;
               end
            end
            ST_RUN_DIAGNOSTICS:
            begin
               if (diag_ready)
               begin
                  state_d = diag_ok ? ST_SOFT_RESET_BIT_GOOD : ST_SOFT_RESET_BIT_BAD;
               end
            end
            ST_EDD_DIAG:
            begin
               if (diag_ready)
               begin
                  state_d = diag_ok ? ST_EDD_GOOD : ST_EDD_BAD;
               end
            end
            ST_SOFT_RESET_BIT_GOOD, ST_SOFT_RESET_BIT_BAD, ST_EDD_GOOD, ST_EDD_BAD:
            begin
               if (frame_done)
               begin
                  state_d = ST_IDLE;
               end
            end
            default:
            begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // diagnostics restart on link reset, soft reset or diagnostic command
   assign diag_restart_d = comreset_i || soft_reset_bit_frame ||
                           (state_q == ST_IDLE && diag_cmd_i);

   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         state_q <= ST_IDLE;
         diag_restart_o <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         diag_restart_o <= diag_restart_d;
      end
   end

   // diagnostics may finish while the soft reset is still held; keep it
   // a finish that lands in a restart cycle is kept, the set wins
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         diag_done_q <= 1'b0;
         diag_pass_q <= 1'b0;
      end
      else if (diag_done_i)
      begin
         diag_done_q <= 1'b1;
         diag_pass_q <= diag_pass_i;
      end
      else if (diag_restart_d)
      begin
         diag_done_q <= 1'b0;
      end
   end

   // serviced command and its tag, caught with the service command
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         dispatch_cmd_o <= CMD_PKT_PIO_IN;
         tag_q <= '0;
      end
      else if (state_q == ST_IDLE && service_cmd_i && !comreset_i && !soft_reset_bit_frame)
      begin
         dispatch_cmd_o <= service_request_bit_cmd_type_i;
         tag_q <= service_request_bit_tag_i;
      end
   end

   reset_signature_gen u_sig (
      .packet_support_i(packet_support_i),
      .good_i(good_state),
      .status_bits_i(status_bits_i),
      .fail_code_i(fail_code_i),
      .count_o(sig_count),
      .lba_o(sig_lba),
      .err_o(sig_err),
      .status_o(sig_status)
   );

   // frame content per sending state
   assign req.want = is_send(state_q) && !comreset_i && !soft_reset_bit_frame;
   assign req.kind = (state_q == ST_SET_SERVICE) ? FRAME_SDB : FRAME_REG_D2H;
   assign req.irq = (state_q != ST_TAG_SEND);
   assign req.count = sig_state ? sig_count
                    : {tag_q, {TAG_LSB{1'b0}}};
   assign req.lba = sig_state ? sig_lba : 24'h000000;
   assign req.err = sig_state ? sig_err : err_reg_i;
   assign req.status = sig_state ? sig_status
                     : (state_q == ST_SET_SERVICE)
                       ? (status_reg_i | 8'(1 << SERVICE_BIT_POS))
                       : 8'(1 << DATA_REQ_BIT_POS);

   tx_request_hold u_hold (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .abort_i(comreset_i),
      .req(req),
      .tx_done_i(tx_done_i),
      .tx_req_o(tx_req_o),
      .tx_kind_o(tx_kind_o),
      .tx_irq_o(tx_irq_o),
      .tx_count_o(tx_count_o),
      .tx_lba_o(tx_lba_o),
      .tx_err_o(tx_err_o),
      .tx_status_o(tx_status_o)
   );

   assign dispatch_valid_o = (state_q == ST_SERVICE_DISPATCH);
   assign idle_o = (state_q == ST_IDLE);

   // checks
   property p_service_request_bit_frame;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_SET_SERVICE && tx_req_o |->
         tx_kind_o == FRAME_SDB && tx_irq_o && tx_status_o[SERVICE_BIT_POS];
   endproperty
   a_service_request_bit_frame: assert property (p_service_request_bit_frame)
      else $error("service frame lacks service or interrupt bit");

   property p_service_request_bit_idle;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_SET_SERVICE && frame_done && !comreset_i && !soft_reset_bit_frame
         |=> state_q == ST_IDLE;
   endproperty
   a_service_request_bit_idle: assert property (p_service_request_bit_idle)
      else $error("no return to idle after service frame");

   property p_check;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_SERVICE_CHECK && !comreset_i && !soft_reset_bit_frame |=>
         state_q == (pio_packet ? ST_SERVICE_DISPATCH : ST_TAG_SEND);
   endproperty
   a_check: assert property (p_check)
      else $error("wrong branch from service check");

   property p_tag;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_TAG_SEND && tx_req_o |->
         tx_count_o[7:TAG_LSB] == tag_q && tx_kind_o == FRAME_REG_D2H;
   endproperty
   a_tag: assert property (p_tag)
      else $error("tag frame carries wrong tag");

   property p_dispatch;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(dispatch_valid_o) |-> ##1 !dispatch_valid_o;
   endproperty
   a_dispatch: assert property (p_dispatch)
      else $error("dispatch held longer than one cycle");

   property p_soft_reset_bit;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      soft_reset_bit_frame && !comreset_i |=> state_q == ST_RESET_ASSERTED && diag_restart_o;
   endproperty
   a_soft_reset_bit: assert property (p_soft_reset_bit)
      else $error("soft reset frame not obeyed");

   property p_release;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_RESET_ASSERTED && release_frame && !comreset_i
         |=> state_q == ST_RUN_DIAGNOSTICS;
   endproperty
   a_release: assert property (p_release)
      else $error("soft reset release not taken");

   property p_hold_reset;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_RESET_ASSERTED && !release_frame && !comreset_i
         |=> state_q == ST_RESET_ASSERTED;
   endproperty
   a_hold_reset: assert property (p_hold_reset)
      else $error("left reset state without release");

   property p_diag_branch;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == ST_RUN_DIAGNOSTICS && diag_done_i && !comreset_i && !soft_reset_bit_frame
         |=> state_q == (diag_pass_i ? ST_SOFT_RESET_BIT_GOOD : ST_SOFT_RESET_BIT_BAD);
   endproperty
   a_diag_branch: assert property (p_diag_branch)
      else $error("diagnostics result ignored");

   property p_sig;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      sig_state && tx_req_o |-> tx_count_o == SIG_COUNT &&
         tx_lba_o[7:0] == SIG_LBA_LOW && tx_err_o <= SIG_ERR_BAD_MAX &&
         (tx_err_o == SIG_ERR_GOOD) == good_state;
   endproperty
   a_sig: assert property (p_sig)
      else $error("reset signature malformed");

   property p_comreset;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      comreset_i |=> state_q == ST_RUN_DIAGNOSTICS && !tx_req_o;
   endproperty
   a_comreset: assert property (p_comreset)
      else $error("link reset did not abandon protocol");

   property p_edd_irq;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      (state_q == ST_EDD_GOOD || state_q == ST_EDD_BAD) && tx_req_o |-> tx_irq_o;
   endproperty
   a_edd_irq: assert property (p_edd_irq)
      else $error("diagnostic status frame without interrupt");
endmodule : device_reset_service_fsm

// *** sim/transport_model.sv ***
`timescale 1ns/100ps
// transport layer stand-in: one done pulse for each held frame request
module transport_model (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic tx_req_i,
   input wire logic [3:0] lag_i,
   output logic tx_done_o
);
   logic [3:0] wait_q;
   // stalls lag_i cycles; never answers a dropped request, so a late done cannot leak
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i || !tx_req_i)
      begin
         wait_q <= 4'h0;
         tx_done_o <= 1'b0;
      end
      else if (tx_done_o)
         tx_done_o <= 1'b0;
      else if (wait_q == lag_i)
         tx_done_o <= 1'b1;
      else
         wait_q <= wait_q + 4'h1;
   end
endmodule : transport_model

// *** sim/test_device_reset_service_fsm.sv ***
`timescale 1ns/100ps
module test_device_reset_service_fsm
   import dev_cmd_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic rx_frame_valid_i = 1'b0;
   logic rx_reg_h2d_i = 1'b0;
   logic rx_cmd_flag_i = 1'b0;
   logic rx_soft_reset_i = 1'b0;
   logic comreset_i = 1'b0;
   logic queue_ready_i = 1'b0;
   logic service_cmd_i = 1'b0;
   cmd_type_t service_request_bit_cmd_type_i = CMD_PKT_PIO_IN;
   logic [TAG_W-1:0] service_request_bit_tag_i = '0;
   logic diag_cmd_i = 1'b0;
   logic diag_done_i = 1'b0;
   logic diag_pass_i = 1'b0;
   logic packet_support_i = 1'b0;
   logic [2:0] status_bits_i = 3'h5;
   logic [7:0] fail_code_i = 8'h2A;
   logic [7:0] err_reg_i = 8'h5A;
   logic [7:0] status_reg_i = 8'h41;
   logic tx_done_i;
   logic tx_req_o;
   frame_kind_t tx_kind_o;
   logic tx_irq_o;
   logic [7:0] tx_count_o;
   logic [23:0] tx_lba_o;
   logic [7:0] tx_err_o;
   logic [7:0] tx_status_o;
   logic dispatch_valid_o;
   cmd_type_t dispatch_cmd_o;
   logic diag_restart_o;
   logic idle_o;
   logic [3:0] lag = 4'h0;
   logic seen_req = 1'b0;
   logic [7:0] seen_cnt;
   logic [23:0] seen_lba;
   int err_total = 0;
   int cmp_count = 0;
   int k;
   int t;

   device_reset_service_fsm u_dut (.ref_clk_i, .rstn_i, .rx_frame_valid_i, .rx_reg_h2d_i,
      .rx_cmd_flag_i, .rx_soft_reset_i, .comreset_i, .queue_ready_i, .service_cmd_i,
      .service_request_bit_cmd_type_i, .service_request_bit_tag_i, .diag_cmd_i, .diag_done_i, .diag_pass_i,
      .packet_support_i, .status_bits_i, .fail_code_i, .err_reg_i, .status_reg_i, .tx_done_i,
      .tx_req_o, .tx_kind_o, .tx_irq_o, .tx_count_o, .tx_lba_o, .tx_err_o, .tx_status_o,
      .dispatch_valid_o, .dispatch_cmd_o, .diag_restart_o, .idle_o);
   transport_model u_far (.ref_clk_i, .rstn_i, .tx_req_i(tx_req_o), .lag_i(lag),
      .tx_done_o(tx_done_i));

   // 20 MHz
   always #25 ref_clk_i = ~ref_clk_i;

   // inputs move 1 ns after the edge, clear of the sampling instant
   task tick;
      @(posedge ref_clk_i);
      #1;
   endtask : tick

   task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // one-cycle strobe; callers leave a tick between two strobes
   task pulse(input int w);
      case (w)
         0: rx_frame_valid_i = 1'b1;
         1: comreset_i = 1'b1;
         2: service_cmd_i = 1'b1;
         3: diag_cmd_i = 1'b1;
         default: diag_done_i = 1'b1;
      endcase
      tick;
      {rx_frame_valid_i, rx_reg_h2d_i, comreset_i, service_cmd_i, diag_cmd_i, diag_done_i} = '0;
   endtask : pulse

   task rx_ctrl(input logic c, input logic s);
      rx_reg_h2d_i = 1'b1;
      rx_cmd_flag_i = c;
      rx_soft_reset_i = s;
      pulse(0);
   endtask : rx_ctrl

   // bounded wait: 0 req up, 1 req down, 2 dispatch, 3 idle, 4 restart
   task wait_for(input int w, input int lim);
      int i;
      logic hit;
      hit = 1'b0;
      for (i = 0; i < lim && !hit; i++)
      begin
         case (w)
            0: hit = tx_req_o === 1'b1;
            1: hit = tx_req_o === 1'b0;
            2: hit = dispatch_valid_o === 1'b1;
            3: hit = idle_o === 1'b1;
            default: hit = diag_restart_o === 1'b1;
         endcase
         seen_req = seen_req | (tx_req_o === 1'b1);
         if (!hit)
            tick;
      end
      check($sformatf("wait %0d", w), hit, 1'b1);
   endtask : wait_for

   // er[8] set: error field left open for this frame
   task frame(input frame_kind_t kd, input logic irq, input logic [7:0] st, input logic [8:0] er);
      wait_for(0, 20);
      check("kind", tx_kind_o, kd);
      check("irq", tx_irq_o, irq);
      check("status", tx_status_o, st);
      if (!er[8])
         check("error", tx_err_o, er[7:0]);
      seen_cnt = tx_count_o;
      seen_lba = tx_lba_o;
      wait_for(1, 20);
   endtask : frame

   task done_test(input string n);
      $display("test %s done, mismatches so far %0d", n, err_total);
   endtask : done_test

   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (2) tick;
      rstn_i = 1'b1;
      check("idle", idle_o, 1'b1);
      check("req", tx_req_o, 1'b0);
      check("kind", tx_kind_o, FRAME_NONE);
      done_test("reset");
      // queued transfer ready: flagged frame under a slow transport
      lag = 4'h5;
      queue_ready_i = 1'b1;
      tick;
      queue_ready_i = 1'b0;
      frame(FRAME_SDB, 1'b1, 8'h51, 9'h05A);
      wait_for(3, 4);
      done_test("service request");
      // every serviced command type, tag frame only when needed
      for (t = 0; t < 6; t++)
      begin
         lag = 4'(t);
         service_request_bit_cmd_type_i = cmd_type_t'(t);
         service_request_bit_tag_i = 5'(t * 5 + 3);
         seen_req = 1'b0;
         pulse(2);
         if (t > 1)
         begin
            frame(FRAME_REG_D2H, 1'b0, 8'h08, 9'h100);
            check("tag", seen_cnt, {service_request_bit_tag_i, 3'h0});
         end
         wait_for(2, 8);
         check("target", dispatch_cmd_o, service_request_bit_cmd_type_i);
         check("tag frame", seen_req, t > 1);
         wait_for(3, 4);
      end
      done_test("service dispatch");
      // soft reset in both families, pass and fail, some results held over
      for (k = 0; k < 4; k++)
      begin
         lag = 4'(k * 2);
         packet_support_i = k[1];
         fail_code_i = k[1] ? 8'h7F : 8'h01;
         diag_pass_i = ~k[0];
         rx_ctrl(1'b0, 1'b1);
         wait_for(4, 3);
         tick;
         rx_ctrl(k[0], ~k[0]);
         tick;
         if (k[0] ^ k[1])
            pulse(4);
         repeat (4) tick;
         check("held req", tx_req_o, 1'b0);
         check("held idle", idle_o, 1'b0);
         rx_ctrl(1'b0, 1'b0);
         tick;
         if (!(k[0] ^ k[1]))
            pulse(4);
         frame(FRAME_REG_D2H, 1'b1, k[1] ? 8'h00 : {1'b0, status_bits_i, 4'h0},
            {1'b0, ~k[0] ? 8'h01 : (k[1] ? 8'h7F : 8'h00)});
         check("sig count", seen_cnt, 8'h01);
         check("sig lba", seen_lba, k[1] ? 24'hEB1401 : 24'h000001);
         wait_for(3, 4);
      end
      done_test("soft reset");
      // diagnostic command, then aborted by link reset and by soft reset
      lag = 4'h3;
      diag_pass_i = 1'b1;
      pulse(3);
      wait_for(4, 3);
      tick;
      pulse(4);
      frame(FRAME_REG_D2H, 1'b1, 8'h00, 9'h001);
      wait_for(3, 4);
      diag_pass_i = 1'b0;
      fail_code_i = 8'h80;
      pulse(3);
      tick;
      pulse(1);
      wait_for(4, 3);
      tick;
      pulse(4);
      frame(FRAME_REG_D2H, 1'b1, 8'h00, 9'h000);
      wait_for(3, 4);
      pulse(3);
      tick;
      rx_ctrl(1'b0, 1'b1);
      wait_for(4, 3);
      tick;
      pulse(4);
      repeat (4) tick;
      check("abort req", tx_req_o, 1'b0);
      rx_ctrl(1'b0, 1'b0);
      frame(FRAME_REG_D2H, 1'b1, 8'h00, 9'h000);
      wait_for(3, 4);
      done_test("diagnostic aborts");
      end_of_test;
   end

   // the sequence needs well under a thousand cycles
   initial
   begin
      #(50 * 3000);
      err_total++;
      $display("BAD watchdog expected finish seen hang");
      end_of_test;
   end
endmodule : test_device_reset_service_fsm
